// [verilog/serial_port_regs.v]
// data, transmit and upper control/status registers of a buffered serial port,
// with a small transmit shifter, rate divider and frame-sync generator behind them.
// assumes all request inputs come from logic on clk_sys_in; rx words arrive from
// the receive engine on the same clock.
//
// Behaviour
// - data-port read anywhere in receive region returns receive data register
// - data-port write anywhere in transmit region acts as a transmit register write
// - receive data register holds a full 32-bit word, read-only, zero at reset
// - transmit register word moves into the transmit shift register for serialising
// - control bits 31..26 read zero and ignore writes
// - free-running bit set keeps serial clocks running during emulation halt
// - free and soft both clear: clock stops at once on halt, transfer abandoned
// - free clear, soft set: current transmission finishes, then the clock stops
// - soft bit is ignored whenever free bit is set
// - frame-sync reset bit low holds frame logic reset, no generated frame sync
// - frame-sync bit high: load counters, sync after frame period plus one clocks
// - rate generator held in reset while bit 22 low, else follows its settings
// - bits 21..20 pick transmit interrupt source: end of frame, sync, sync error
// - bit 19 reports sync error; writing one sets it while transmitter enabled or when the same write sets bit 16
// - every control register field clears to zero at reset
// - bit 18 reads one when the transmit shift register holds a word
// - bit 17 reads one when the transmitter can accept a new word
// - bit 16 low keeps transmitter disabled and in reset, high enables it
`timescale 1ns/1ps
`include "serial_port_map.vh"

module serial_port_regs #(
  parameter DIV_W = 8,                          // rate divider width
  parameter PER_W = 12                          // frame period width
) (
  // clock, reset, enable
  input  wire              clk_sys_in,
  input  wire              srst_in,
  input  wire              ce_in,
  // configuration bus
  input  wire              cfg_sel_in,
  input  wire              cfg_wr_in,
  input  wire [7:0]        cfg_addr_in,
  input  wire [31:0]       cfg_wdata_in,
  output reg  [31:0]       cfg_rdata_out,
  output reg               cfg_rvalid_out,
  // data-port bus
  input  wire              dp_sel_in,
  input  wire              dp_wr_in,
  input  wire [15:0]       dp_addr_in,
  input  wire [31:0]       dp_wdata_in,
  output reg  [31:0]       dp_rdata_out,
  output reg               dp_rvalid_out,
  output reg               dp_tx_ready_out,
  // receive engine
  input  wire              rx_word_valid_in,
  input  wire [31:0]       rx_word_in,
  // generator settings and emulation
  input  wire [DIV_W-1:0]  gen_div_in,
  input  wire [PER_W-1:0]  frame_period_in,
  input  wire              emu_halt_in,
  // serial side
  output reg               tx_bit_out,
  output reg               generator_clock_out,
  output reg               generated_frame_sync_out,
  output reg               tx_interrupt_out
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function is_cfg;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_cfg = (addr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  reg              free_q;
  reg              soft_q;
  reg              fsg_rst_n_q;
  reg              gen_rst_n_q;
  reg  [1:0]       tx_int_mode_q;
  reg              sync_err_q;
  reg              tx_en_q;
  reg  [31:0]      receive_data_reg_q;
  reg  [31:0]      transmit_data_reg_q;
  reg  [31:0]      fifo_mem_q [0:1];
  reg              fifo_wp_q;
  reg              fifo_rp_q;
  reg  [1:0]       fifo_cnt_q;
  reg  [31:0]      transmit_shift_reg_q;
  reg  [5:0]       bits_left_q;
  reg  [DIV_W-1:0] div_cnt_q;
  reg  [PER_W-1:0] per_cnt_q;
  reg              frame_end_q;

  wire cfg_wr = cfg_sel_in & cfg_wr_in;
  wire cfg_rd = cfg_sel_in & ~cfg_wr_in;
  wire dp_tx  = dp_addr_in[`DP_REGION_BIT] == `DP_REGION_TX;

  // tx write from either bus; both on one cycle keeps the data-port word
  wire cfg_tx_wr = cfg_wr & is_cfg(cfg_addr_in, `OFS_TRANSMIT_DATA);
  wire dp_tx_wr  = dp_sel_in & dp_wr_in & dp_tx;
  wire tx_wr     = cfg_tx_wr | dp_tx_wr;
  wire [31:0] tx_wdata = dp_tx_wr ? dp_wdata_in : cfg_wdata_in;
  wire ctl_wr    = cfg_wr & is_cfg(cfg_addr_in, `OFS_PORT_CTRL_STAT);

  // ----------------------------------------------------------------
  // serial clock gating and generator tick
  // ----------------------------------------------------------------
  wire shifting  = bits_left_q != 6'd0;
  // soft stop lets the word in flight finish; free overrides soft entirely
  wire clk_run   = free_q | ~emu_halt_in | (soft_q & shifting);
  wire gen_tick  = gen_rst_n_q & clk_run & (div_cnt_q == {DIV_W{1'b0}});
  wire fifo_full = fifo_cnt_q == 2'd2;
  wire fifo_has  = fifo_cnt_q != 2'd0;
  wire load_sr   = tx_en_q & fifo_has & ~shifting & gen_tick;
  wire fs_pulse  = fsg_rst_n_q & gen_tick & (per_cnt_q == {PER_W{1'b0}});
  // a frame sync arriving mid-word is a transmit sync error
  wire sync_evt  = tx_en_q & fs_pulse & shifting & (bits_left_q != 6'd1);
  wire push      = tx_wr & ~fifo_full & tx_en_q;
  // halt without soft or free abandons the word in flight
  wire abort     = emu_halt_in & ~free_q & ~soft_q;

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      free_q        <= 1'b0;
      soft_q        <= 1'b0;
      fsg_rst_n_q   <= 1'b0;
      gen_rst_n_q   <= 1'b0;
      tx_int_mode_q <= `TX_INTERRUPT_MODE_RESERVED;
      tx_en_q       <= 1'b0;
    end else if (ce_in && ctl_wr) begin
      // bits 31..26 and 18..17 are not stored
      free_q        <= cfg_wdata_in[`CTL_FREE_BIT];
      soft_q        <= cfg_wdata_in[`CTL_SOFT_BIT];
      fsg_rst_n_q   <= cfg_wdata_in[`CTL_FSG_RST_BIT];
      gen_rst_n_q   <= cfg_wdata_in[`CTL_GEN_RST_BIT];
      tx_int_mode_q <= cfg_wdata_in[`CTL_TX_INTERRUPT_MODE_HI:`CTL_TX_INTERRUPT_MODE_LO];
      tx_en_q       <= cfg_wdata_in[`CTL_TX_ENABLE_RESET_N_BIT];
    end
  end

  // sync error: hardware set wins over a software clear in the same cycle
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      sync_err_q <= 1'b0;
    end else if (ce_in) begin
      if (sync_evt) begin
        sync_err_q <= 1'b1;
      end else if (ctl_wr) begin
        sync_err_q <= cfg_wdata_in[`CTL_TX_SYNC_ERROR_BIT] &
                      (tx_en_q | cfg_wdata_in[`CTL_TX_ENABLE_RESET_N_BIT] | ~cfg_wdata_in[`CTL_TX_SYNC_ERROR_BIT]);
      end
    end
  end

  // ----------------------------------------------------------------
  // receive data register
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      receive_data_reg_q <= `RESET_WORD;
    end else if (ce_in && rx_word_valid_in) begin
      receive_data_reg_q <= rx_word_in;
    end
  end

  // ----------------------------------------------------------------
  // transmit register and two-entry buffer ahead of the shifter
  // ----------------------------------------------------------------
  // the buffer lets the bus post a second word while one is still shifting;
  // a write while full is dropped, so writers must watch the ready flag
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      transmit_data_reg_q <= `RESET_WORD;
      fifo_wp_q           <= 1'b0;
      fifo_rp_q           <= 1'b0;
      fifo_cnt_q          <= 2'd0;
      fifo_mem_q[0]       <= `RESET_WORD;
      fifo_mem_q[1]       <= `RESET_WORD;
    end else if (ce_in) begin
      if (!tx_en_q) begin
        fifo_wp_q  <= 1'b0;
        fifo_rp_q  <= 1'b0;
        fifo_cnt_q <= 2'd0;
      end else begin
        if (push) begin
          transmit_data_reg_q   <= tx_wdata;
          fifo_mem_q[fifo_wp_q] <= tx_wdata;
          fifo_wp_q             <= ~fifo_wp_q;
        end
        if (load_sr) begin
          fifo_rp_q <= ~fifo_rp_q;
        end
        fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, load_sr};
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit shift register
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      transmit_shift_reg_q <= `RESET_WORD;
      bits_left_q          <= 6'd0;
      frame_end_q          <= 1'b0;
    end else if (ce_in) begin
      frame_end_q <= 1'b0;
      if (!tx_en_q || abort) begin
        bits_left_q <= 6'd0;
      end else if (load_sr) begin
        transmit_shift_reg_q <= fifo_mem_q[fifo_rp_q];
        bits_left_q          <= 6'd`WORD_BITS;
      end else if (gen_tick && shifting) begin
        transmit_shift_reg_q <= {transmit_shift_reg_q[30:0], 1'b0};
        bits_left_q          <= bits_left_q - 6'd1;
        frame_end_q          <= bits_left_q == 6'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // rate divider and frame-sync generator
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      div_cnt_q <= {DIV_W{1'b0}};
      per_cnt_q <= {PER_W{1'b0}};
    end else if (ce_in) begin
      if (!gen_rst_n_q) begin
        div_cnt_q <= {DIV_W{1'b0}};
      end else if (clk_run) begin
        div_cnt_q <= (div_cnt_q == {DIV_W{1'b0}}) ? gen_div_in : div_cnt_q - 1'b1;
      end
      // counter reloads with the period while held, so the first sync
      // lands after period plus one generator clocks
      if (!fsg_rst_n_q) begin
        per_cnt_q <= frame_period_in;
      end else if (gen_tick) begin
        per_cnt_q <= (per_cnt_q == {PER_W{1'b0}}) ? frame_period_in : per_cnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial outputs and interrupt
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      tx_bit_out               <= 1'b0;
      generator_clock_out      <= 1'b0;
      generated_frame_sync_out <= 1'b0;
      tx_interrupt_out         <= 1'b0;
      dp_tx_ready_out          <= 1'b0;
    end else if (ce_in) begin
      tx_bit_out               <= shifting & transmit_shift_reg_q[31];
      generator_clock_out      <= gen_tick;
      generated_frame_sync_out <= fs_pulse;
      dp_tx_ready_out          <= tx_en_q & ~fifo_full;
      case (tx_int_mode_q)
        `TX_INTERRUPT_MODE_END_FRAME:  tx_interrupt_out <= frame_end_q;
        `TX_INTERRUPT_MODE_FRAME_SYNC: tx_interrupt_out <= fs_pulse;
        `TX_INTERRUPT_MODE_SYNC_ERR:   tx_interrupt_out <= sync_evt;
        default:           tx_interrupt_out <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read paths
  // ----------------------------------------------------------------
  wire [31:0] ctl_word = {6'h00,
                          free_q, soft_q, fsg_rst_n_q, gen_rst_n_q,
                          tx_int_mode_q, sync_err_q,
                          shifting,
                          tx_en_q & ~fifo_full,
                          tx_en_q, 16'h0000};

  // unmapped config addresses read zero; reads answer one cycle later
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      cfg_rdata_out  <= `RESET_WORD;
      cfg_rvalid_out <= 1'b0;
      dp_rdata_out   <= `RESET_WORD;
      dp_rvalid_out  <= 1'b0;
    end else if (ce_in) begin
      cfg_rvalid_out <= cfg_rd;
      if (cfg_rd) begin
        if (is_cfg(cfg_addr_in, `OFS_RECEIVE_DATA)) begin
          cfg_rdata_out <= receive_data_reg_q;
        end else if (is_cfg(cfg_addr_in, `OFS_TRANSMIT_DATA)) begin
          cfg_rdata_out <= transmit_data_reg_q;
        end else if (is_cfg(cfg_addr_in, `OFS_PORT_CTRL_STAT)) begin
          cfg_rdata_out <= ctl_word;
        end else begin
          cfg_rdata_out <= `RESET_WORD;
        end
      end
      dp_rvalid_out <= dp_sel_in & ~dp_wr_in;
      if (dp_sel_in && !dp_wr_in) begin
        dp_rdata_out <= dp_tx ? `RESET_WORD : receive_data_reg_q;
      end
    end
  end

endmodule // serial_port_regs

// [common/serial_port_map.vh]
// register map, field positions, reset values and timing for the serial port register bank
// assumes 32-bit word buses; register offsets are byte addresses, word aligned
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH

// ----------------------------------------------------------------
// configuration bus offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_RECEIVE_DATA     8'h00
`define OFS_TRANSMIT_DATA    8'h04
`define OFS_PORT_CTRL_STAT   8'h08

// ----------------------------------------------------------------
// data-port bus regions: address bit that selects the region
// ----------------------------------------------------------------
`define DP_REGION_BIT        12
`define DP_REGION_RX         1'b0
`define DP_REGION_TX         1'b1

// ----------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------
`define CTL_RSVD_HI          31
`define CTL_RSVD_LO          26
`define CTL_FREE_BIT         25
`define CTL_SOFT_BIT         24
`define CTL_FSG_RST_BIT      23
`define CTL_GEN_RST_BIT      22
`define CTL_TX_INTERRUPT_MODE_HI         21
`define CTL_TX_INTERRUPT_MODE_LO         20
`define CTL_TX_SYNC_ERROR_BIT     19
`define CTL_TX_SHIFT_NONEMPTY_BIT       18
`define CTL_TX_READY_FLAG_BIT         17
`define CTL_TX_ENABLE_RESET_N_BIT         16

// ----------------------------------------------------------------
// interrupt mode codes and reset values
// ----------------------------------------------------------------
`define TX_INTERRUPT_MODE_RESERVED       2'h0
`define TX_INTERRUPT_MODE_END_FRAME      2'h1
`define TX_INTERRUPT_MODE_FRAME_SYNC     2'h2
`define TX_INTERRUPT_MODE_SYNC_ERR       2'h3
`define RESET_WORD           32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        8
`define WORD_BITS            32

`endif

// [test/dma_agent.sv]
// data-port master standing in for the transfer controller on the far side
// assumes one caller at a time; each access is a one-cycle strobe on clk_sys_in
`timescale 1ns/1ps
module dma_agent (
  // clock
  input  wire        clk_sys_in,
  // data-port requests
  output reg         dp_sel_out,
  output reg         dp_wr_out,
  output reg  [15:0] dp_addr_out,
  output reg  [31:0] dp_wdata_out,
  // answers
  input  wire [31:0] dp_rdata_in,
  input  wire        dp_rvalid_in
);
  // idle bus at time zero
  initial begin
    {dp_sel_out, dp_wr_out} = 2'h0;
    {dp_addr_out, dp_wdata_out} = 48'h0;
  end
  // all port traffic goes over the data port, keeping the config bus free
  // released lines are inverted so stale values cannot pass for fresh ones
  task xfer(input wr, input [15:0] addr, input [31:0] data, output [31:0] q, output v);
    begin
      @(posedge clk_sys_in);
      #1 dp_sel_out = 1'b1;
      dp_wr_out = wr;
      dp_addr_out = addr;
      dp_wdata_out = data;
      @(posedge clk_sys_in);
      #1 dp_sel_out = 1'b0;
      dp_addr_out = ~addr;
      dp_wdata_out = ~data;
      q = dp_rdata_in;
      v = dp_rvalid_in;
    end
  endtask
endmodule // dma_agent

// [test/serial_port_regs_sva.sv]
// concurrent checks on the serial port register bank, from its ports only
// assumes one clock domain and a bind onto serial_port_regs
`timescale 1ns/1ps
`include "serial_port_map.vh"
module serial_port_regs_sva (
  // clock, reset, enable, strobes
  input wire        clk_sys_in, srst_in, ce_in, cfg_sel_in, cfg_wr_in, dp_sel_in, dp_wr_in,
  // addresses and data
  input wire [7:0]  cfg_addr_in,
  input wire [15:0] dp_addr_in,
  input wire [31:0] cfg_wdata_in, cfg_rdata_out, dp_rdata_out, rx_word_in,
  // answers and serial side
  input wire        cfg_rvalid_out, dp_rvalid_out, dp_tx_ready_out, rx_word_valid_in,
  input wire        generator_clock_out, generated_frame_sync_out
);
  reg [31:0] ctl_q;
  reg [31:0] rx_q;
  // shadows of control and received word; hardware-set status bits are not tracked
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctl_q <= 32'h0000_0000;
      rx_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (cfg_sel_in && cfg_wr_in && cfg_addr_in == `OFS_PORT_CTRL_STAT) ctl_q <= cfg_wdata_in;
      if (rx_word_valid_in) rx_q <= rx_word_in;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  a_cfg_read_answer: assert property (ce_in && cfg_sel_in && !cfg_wr_in |=> cfg_rvalid_out)
    else $error("config read not answered");
  a_dp_read_answer: assert property (ce_in && dp_sel_in && !dp_wr_in |=> dp_rvalid_out)
    else $error("data-port read not answered");
  a_dp_read_data: assert property (
    dp_rvalid_out |-> dp_rdata_out == ($past(dp_addr_in[12]) ? 32'h0 : $past(rx_q)))
    else $error("data-port read data wrong");
  a_reserved_read_zero: assert property (
    cfg_rvalid_out && $past(cfg_addr_in) == `OFS_PORT_CTRL_STAT
    |-> cfg_rdata_out[31:26] == 6'h00 && cfg_rdata_out[15:0] == 16'h0000)
    else $error("reserved control bits read nonzero");
  a_mode_bits_readback: assert property (
    cfg_rvalid_out && $past(cfg_addr_in) == `OFS_PORT_CTRL_STAT
    |-> cfg_rdata_out[25:20] == $past(ctl_q[25:20]) && cfg_rdata_out[16] == $past(ctl_q[16]))
    else $error("control field readback wrong");
  a_outputs_quiet_reset: assert property ($past(srst_in) |->
    !cfg_rvalid_out && !dp_rvalid_out && !generator_clock_out && !generated_frame_sync_out)
    else $error("output active right after reset");
  a_fsync_held_off: assert property ((!ctl_q[23]) [*2] |-> !generated_frame_sync_out)
    else $error("frame sync while its generator is in reset");
  a_gen_held_off: assert property ((!ctl_q[22]) [*2] |-> !generator_clock_out)
    else $error("generator tick while generator is in reset");
  a_ready_needs_enable: assert property ((!ctl_q[16]) [*2] |-> !dp_tx_ready_out)
    else $error("transmitter ready while disabled");
  c_ctl_read: cover property (cfg_rvalid_out && $past(cfg_addr_in) == `OFS_PORT_CTRL_STAT);
  c_frame_sync: cover property (generated_frame_sync_out);
  c_buffer_full: cover property (ctl_q[16] && !dp_tx_ready_out);
endmodule // serial_port_regs_sva

bind serial_port_regs serial_port_regs_sva serial_port_regs_sva_i (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in), .cfg_sel_in(cfg_sel_in),
  .cfg_wr_in(cfg_wr_in), .dp_sel_in(dp_sel_in), .dp_wr_in(dp_wr_in), .cfg_addr_in(cfg_addr_in),
  .dp_addr_in(dp_addr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
  .dp_rdata_out(dp_rdata_out), .rx_word_in(rx_word_in), .cfg_rvalid_out(cfg_rvalid_out),
  .dp_rvalid_out(dp_rvalid_out), .dp_tx_ready_out(dp_tx_ready_out),
  .rx_word_valid_in(rx_word_valid_in), .generator_clock_out(generator_clock_out),
  .generated_frame_sync_out(generated_frame_sync_out));

// [test/serial_port_regs_test.sv]
// self-checking bench: config bus task, data-port master model, reference values
// assumes serial_port_regs, dma_agent and the checker are compiled alongside
`timescale 1ns/1ps
`include "serial_port_map.vh"
module serial_port_regs_test;
  reg          clk_sys_in, srst_in, cfg_sel_in, cfg_wr_in, rx_word_valid_in, emu_halt_in;
  reg  [7:0]   cfg_addr_in, gen_div_in;
  reg  [11:0]  frame_period_in;
  reg  [31:0]  cfg_wdata_in, rx_word_in;
  wire         cfg_rvalid_out, dp_sel_in, dp_wr_in, dp_rvalid_out, dp_tx_ready_out;
  wire         tx_bit_out, generator_clock_out, generated_frame_sync_out, tx_interrupt_out;
  wire [15:0]  dp_addr_in;
  wire [31:0]  cfg_rdata_out, dp_wdata_in, dp_rdata_out;
  integer      miscompares, check_count;
  integer      ticks = 0, syncs = 0, ints = 0;
  reg  [1:0]   tick_d = 2'h0;
  reg  [127:0] ser = 128'h0;
  serial_port_regs serial_port_regs_i (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(1'b1), .cfg_sel_in(cfg_sel_in),
    .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out), .dp_sel_in(dp_sel_in),
    .dp_wr_in(dp_wr_in), .dp_addr_in(dp_addr_in), .dp_wdata_in(dp_wdata_in),
    .dp_rdata_out(dp_rdata_out), .dp_rvalid_out(dp_rvalid_out),
    .dp_tx_ready_out(dp_tx_ready_out), .rx_word_valid_in(rx_word_valid_in),
    .rx_word_in(rx_word_in), .gen_div_in(gen_div_in), .frame_period_in(frame_period_in),
    .emu_halt_in(emu_halt_in), .tx_bit_out(tx_bit_out), .generator_clock_out(generator_clock_out),
    .generated_frame_sync_out(generated_frame_sync_out), .tx_interrupt_out(tx_interrupt_out));
  dma_agent dma_agent_i (
    .clk_sys_in(clk_sys_in), .dp_sel_out(dp_sel_in), .dp_wr_out(dp_wr_in),
    .dp_addr_out(dp_addr_in), .dp_wdata_out(dp_wdata_in), .dp_rdata_in(dp_rdata_out),
    .dp_rvalid_in(dp_rvalid_out));
  // ---------------------------------------------------------------
  // clock, monitors, shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // serial bit sampled two cycles after a tick, mid-bit whatever the launch edge
  always @(posedge clk_sys_in) begin
    tick_d <= {tick_d[0], generator_clock_out === 1'b1};
    if (tick_d[1]) ser <= {ser[126:0], tx_bit_out};
    if (generator_clock_out === 1'b1) ticks <= ticks + 1;
    if (generated_frame_sync_out === 1'b1) syncs <= syncs + 1;
    if (tx_interrupt_out === 1'b1) ints <= ints + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cfg(input wr, input [7:0] addr, input [31:0] data, output [31:0] q);
    begin
      @(posedge clk_sys_in);
      #1 {cfg_sel_in, cfg_wr_in, cfg_addr_in, cfg_wdata_in} = {1'b1, wr, addr, data};
      @(posedge clk_sys_in);
      #1 {cfg_sel_in, cfg_wdata_in} = {1'b0, ~data};
      q = cfg_rdata_out;
      if (!wr) chk({31'h0, cfg_rvalid_out}, 32'h1);
    end
  endtask
  // bounded wait for a frame sync, then one edge so counters have seen it
  task wait_sync;
    integer n;
    begin
      n = 0;
      while (generated_frame_sync_out !== 1'b1 && n < 400) begin
        @(posedge clk_sys_in);
        #1 n = n + 1;
      end
      chk({31'h0, generated_frame_sync_out}, 32'h1);
      @(posedge clk_sys_in);
      #1;
    end
  endtask
  task summarize;
    begin
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #(8 * 20000);
    miscompares = miscompares + 1;
    summarize;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin : main
    reg [31:0] got, w1, w2;
    reg        ok;
    integer    i, k, t0, k1, k2, i0, s0;
    {cfg_sel_in, cfg_wr_in, rx_word_valid_in, emu_halt_in, cfg_addr_in} = 12'h000;
    {cfg_wdata_in, rx_word_in} = 64'h0;
    {miscompares, check_count} = 64'h0;
    {gen_div_in, frame_period_in} = {8'h03, 12'h003};
    srst_in = 1'b1;
    got = $urandom(90201);
    repeat (20) @(posedge clk_sys_in);
    #1 srst_in = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      cfg(1'b0, {i[5:0], 2'b00}, 32'h0, got);
      chk(got, `RESET_WORD);
    end
    // received word on both buses; config writes to it have no effect
    @(posedge clk_sys_in);
    #1 {rx_word_valid_in, rx_word_in} = {1'b1, $urandom};
    w1 = rx_word_in;
    @(posedge clk_sys_in);
    #1 {rx_word_valid_in, rx_word_in} = {1'b0, ~w1};
    dma_agent_i.xfer(1'b0, $urandom & 16'hefec, 32'h0, got, ok);
    chk({got[30:0], ok}, {w1[30:0], 1'b1});
    dma_agent_i.xfer(1'b0, 16'h1000, 32'h0, got, ok);
    chk(got, 32'h0);
    cfg(1'b1, `OFS_RECEIVE_DATA, ~w1, got);
    cfg(1'b0, `OFS_RECEIVE_DATA, 32'h0, got);
    chk(got, w1);
    // every interrupt mode, reserved and status bits written as random ones
    for (i = 0; i < 4; i = i + 1) begin
      w1 = ($urandom & 32'hffce_ffff) | (i << 20);
      cfg(1'b1, `OFS_PORT_CTRL_STAT, w1, got);
      cfg(1'b0, `OFS_PORT_CTRL_STAT, 32'h0, got);
      chk(got, w1 & 32'h03f0_0000);
    end
    cfg(1'b1, `OFS_PORT_CTRL_STAT, 32'h0009_0000, got);
    cfg(1'b0, `OFS_PORT_CTRL_STAT, 32'h0, got);
    chk(got, 32'h000b_0000);
    // two words fill the buffer with the generator held; a third is dropped
    cfg(1'b1, `OFS_PORT_CTRL_STAT, 32'h0011_0000, got);
    w1 = $urandom | 32'h8000_0000;
    w2 = $urandom;
    dma_agent_i.xfer(1'b1, ($urandom & 16'hfffc) | 16'h1000, w1, got, ok);
    chk({31'h0, dp_tx_ready_out}, 32'h1);
    dma_agent_i.xfer(1'b1, ($urandom & 16'hfffc) | 16'h1000, w2, got, ok);
    // ready is registered, so the full buffer shows one edge after the push
    @(posedge clk_sys_in);
    #1 chk({31'h0, dp_tx_ready_out}, 32'h0);
    cfg(1'b1, `OFS_TRANSMIT_DATA, ~w2, got);
    cfg(1'b0, `OFS_TRANSMIT_DATA, 32'h0, got);
    chk(got, w2);
    i0 = ints;
    cfg(1'b1, `OFS_PORT_CTRL_STAT, 32'h0051_0000, got);
    repeat (12) @(posedge clk_sys_in);
    cfg(1'b0, `OFS_PORT_CTRL_STAT, 32'h0, got);
    chk(got & 32'h0004_0000, 32'h0004_0000);
    repeat (320) @(posedge clk_sys_in);
    {k1, k2} = {32'd0, 32'd200};
    for (k = 0; k <= 96; k = k + 1) begin
      if (ser[k +: 32] === w1) k1 = k;
      if (ser[k +: 32] === w2) k2 = k;
    end
    chk(k1 >= k2 + 32, 1);
    chk(ints - i0, 2);
    cfg(1'b0, `OFS_PORT_CTRL_STAT, 32'h0, got);
    chk(got & 32'h0006_0000, 32'h0002_0000);
    // frame syncs every period-plus-one ticks, each one raising an interrupt
    cfg(1'b1, `OFS_PORT_CTRL_STAT, 32'h00e0_0000, got);
    wait_sync;
    {t0, i0, s0} = {ticks, ints, syncs};
    wait_sync;
    chk(ticks - t0, frame_period_in + 1);
    repeat (2) @(posedge clk_sys_in);
    chk(syncs - s0, 1);
    chk(ints - i0, syncs - s0);
    // halt with free/soft set to 3, 2, then 0: only free keeps ticks going
    for (i = 0; i < 3; i = i + 1) begin
      cfg(1'b1, `OFS_PORT_CTRL_STAT, 32'h0040_0000 | (((i == 2) ? 0 : 3 - i) << 24), got);
      emu_halt_in = 1'b1;
      repeat (4) @(posedge clk_sys_in);
      #1 t0 = ticks;
      repeat (40) @(posedge clk_sys_in);
      #1 emu_halt_in = 1'b0;
      chk(ticks != t0, i != 2);
    end
    // frame syncs every four ticks land mid-word: sync error flag and its interrupt
    t0 = ints;
    cfg(1'b1, `OFS_PORT_CTRL_STAT, 32'h00f1_0000, got);
    dma_agent_i.xfer(1'b1, 16'h1000, w1, got, ok);
    repeat (60) @(posedge clk_sys_in);
    cfg(1'b0, `OFS_PORT_CTRL_STAT, 32'h0, got);
    chk(got & 32'h0008_0000, 32'h0008_0000);
    chk(ints > t0, 1);
    summarize;
  end
endmodule // serial_port_regs_test
